// ===== src/power_good_output_mask_bank.sv
// Power-good aggregation for output pins four and two behind an APB slave.
// Assumes all power-good and enable inputs are asynchronous pins and that
// the OTP source select is static once the device leaves reset.
`timescale 1ns/1ps
`include "pg_mask_defines.svh"

module power_good_output_mask_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`REG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] step_down_rail_pg,
    input wire logic switch_a_one_pg,
    input wire logic adj_ldo_two_pg,
    input wire logic adj_ldo_three_pg,
    input wire logic switch_b_one_pg,
    input wire logic switch_b_two_pg,
    input wire logic adj_ldo_one_pg,
    input wire logic termination_regulator_pg,
    input wire logic enable_input_one,
    input wire logic enable_input_two,
    input wire logic enable_input_four,
    input wire logic enable_input_five,
    input wire logic otp_shared_is_ldo,
    output logic pg_output_pin_four,
    output logic pg_output_pin_two
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    logic [17:0] raw_in;
    logic [17:0] meta_q;
    logic [17:0] sync_q;

    // All pins are gathered so one two-stage chain covers them.
    // Layout: 17 strap, 16..13 enables five/four/two/one, 12 termination,
    // 11 ldo one, 10 switch b two, 9 switch b one, 8 ldo three,
    // 7 ldo two, 6 switch a one, 5..0 step-down rails.
    assign raw_in = {otp_shared_is_ldo, enable_input_five, enable_input_four,
        enable_input_two, enable_input_one, termination_regulator_pg,
        adj_ldo_one_pg, switch_b_two_pg, switch_b_one_pg, adj_ldo_three_pg,
        adj_ldo_two_pg, switch_a_one_pg, step_down_rail_pg};

    // The first stage feeds only the second, which everything else reads.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 18'h00000;
            sync_q <= 18'h00000;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // OTP strap capture.

    logic strap_taken_q;
    logic strap_taken_d;
    logic shared_is_ldo_q;
    logic shared_is_ldo_d;
    logic [1:0] strap_cnt_q;
    logic [1:0] strap_cnt_d;

    // The synchroniser is cleared by reset, so the strap is only taken once
    // the chain holds the real pin; later pin noise cannot flip it.
    always_comb begin
        strap_cnt_d = strap_taken_q ? strap_cnt_q : strap_cnt_q + 2'h1;
        strap_taken_d = strap_taken_q || (strap_cnt_q == `STRAP_SETTLE);
        shared_is_ldo_d = strap_taken_q ? shared_is_ldo_q : sync_q[17];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt_q <= 2'h0;
            strap_taken_q <= 1'b0;
            shared_is_ldo_q <= 1'b0;
        end else begin
            strap_cnt_q <= strap_cnt_d;
            strap_taken_q <= strap_taken_d;
            shared_is_ldo_q <= shared_is_ldo_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source vectors laid out like the mask registers.

    logic [7:0] src_a;
    logic [7:0] src_b;
    logic shared_pg;

    // [RQ5] OTP picks shared source.
    assign shared_pg = shared_is_ldo_q ? sync_q[11] : sync_q[10];

    // [RQ2] Rail layout, mask A.
    assign src_a = {sync_q[7], sync_q[6], sync_q[5:0]};

    // [RQ3] Enable inputs, mask B.
    // [RQ4] Other rails, mask B.
    assign src_b = {sync_q[16], sync_q[15], sync_q[14], sync_q[13],
        sync_q[12], shared_pg, sync_q[9], sync_q[8]};

    ////////////////////////////////////////////////////////////////////////
    // APB slave and mask registers.

    pg_mask_pkg::mask_type pin4_a_q, pin4_a_d;
    pg_mask_pkg::mask_type pin4_b_q, pin4_b_d;
    pg_mask_pkg::mask_type pin2_a_q, pin2_a_d;
    pg_mask_pkg::reg_sel_type sel;
    logic [31:0] prdata_d;
    logic pready_d;
    logic pslverr_d;
    logic xfer_done;

    // Word-aligned decode; the low address bits must be zero.
    always_comb begin
        if (paddr == {2'b00, `PGPIN4_MASK_A_IDX, 2'b00}) begin
            sel = pg_mask_pkg::SEL_PIN4_A;
        end else if (paddr == {2'b00, `PGPIN4_MASK_B_IDX, 2'b00}) begin
            sel = pg_mask_pkg::SEL_PIN4_B;
        end else if (paddr == {2'b00, `PGPIN2_MASK_A_IDX, 2'b00}) begin
            sel = pg_mask_pkg::SEL_PIN2_A;
        end else begin
            sel = pg_mask_pkg::SEL_NONE;
        end
    end

    // One wait state keeps all bus outputs registered.
    assign xfer_done = psel && penable && pready;

    // [RQ7] Masks read and write.
    always_comb begin
        pin4_a_d = pin4_a_q;
        pin4_b_d = pin4_b_q;
        pin2_a_d = pin2_a_q;
        pready_d = psel && penable && !pready;
        pslverr_d = psel && penable && !pready &&
            (sel == pg_mask_pkg::SEL_NONE);
        prdata_d = 32'h00000000;
        if (psel && penable && !pready && !pwrite) begin
            case (sel)
                pg_mask_pkg::SEL_PIN4_A: prdata_d = {24'h000000, pin4_a_q};
                pg_mask_pkg::SEL_PIN4_B: prdata_d = {24'h000000, pin4_b_q};
                pg_mask_pkg::SEL_PIN2_A: prdata_d = {24'h000000, pin2_a_q};
                default: prdata_d = 32'h00000000;
            endcase
        end
        if (xfer_done && pwrite) begin
            case (sel)
                pg_mask_pkg::SEL_PIN4_A: pin4_a_d = pwdata[7:0];
                pg_mask_pkg::SEL_PIN4_B: pin4_b_d = pwdata[7:0];
                pg_mask_pkg::SEL_PIN2_A: pin2_a_d = pwdata[7:0];
                default: pin4_a_d = pin4_a_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin4_a_q <= `MASK_RESET;
            pin4_b_q <= `MASK_RESET;
            pin2_a_q <= `MASK_RESET;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pin4_a_q <= pin4_a_d;
            pin4_b_q <= pin4_b_d;
            pin2_a_q <= pin2_a_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-good trees.

    logic [7:0] keep4_a;
    logic [7:0] keep4_b;
    logic [7:0] keep2_a;
    logic pin4_d;
    logic pin2_d;

    // [RQ7] Set bit forces good.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_term
            assign keep4_a[gi] = src_a[gi] | pin4_a_q[gi];
            assign keep4_b[gi] = src_b[gi] | pin4_b_q[gi];
            assign keep2_a[gi] = src_a[gi] | pin2_a_q[gi];
        end
    endgenerate

    // [RQ1] AND of unmasked terms.
    // [RQ6] Pin two uses rail mask only.
    always_comb begin
        pin4_d = (&keep4_a) & (&keep4_b);
        pin2_d = &keep2_a;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_output_pin_four <= 1'b0;
            pg_output_pin_two <= 1'b0;
        end else begin
            pg_output_pin_four <= pin4_d;
            pg_output_pin_two <= pin2_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    tree_and_a: assert property ( // [RQ1]
        pg_output_pin_four == ($past(&(src_a | pin4_a_q)) &&
        $past(&(src_b | pin4_b_q))))
        else $error("Pin four differs from its masked AND.");

    rail_mask_a: assert property ( // [RQ2]
        (pin4_a_q == 8'hFF && pin4_b_q == 8'hFF) |=> pg_output_pin_four)
        else $error("Fully masked pin four not high.");

    enable_mask_a: assert property ( // [RQ3]
        (!sync_q[16] && !pin4_b_q[`MB_EN_FIVE]) |=> !pg_output_pin_four)
        else $error("Unmasked low enable five did not drop pin four.");

    term_mask_a: assert property ( // [RQ4]
        (!sync_q[12] && !pin4_b_q[`MB_TERM]) |=> !pg_output_pin_four)
        else $error("Unmasked low termination did not drop pin four.");

    shared_select_a: assert property ( // [RQ5]
        $past(strap_taken_q) |-> $stable(shared_is_ldo_q))
        else $error("Shared source select moved after capture.");

    pin_two_a: assert property ( // [RQ6]
        (!sync_q[0] && !pin2_a_q[0]) |=> !pg_output_pin_two)
        else $error("Unmasked low rail one did not drop pin two.");

    mask_write_a: assert property ( // [RQ7]
        (xfer_done && pwrite && sel == pg_mask_pkg::SEL_PIN4_B) |=>
        pin4_b_q == $past(pwdata[7:0]))
        else $error("Mask write did not land.");

    bus_wait_a: assert property (
        (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("Slave did not answer after one wait state.");

    read_cov: cover property (xfer_done && !pwrite && !pslverr);
    write_cov: cover property (xfer_done && pwrite && !pslverr);
    pin4_rise_cov: cover property ($rose(pg_output_pin_four));
    pin2_fall_cov: cover property ($fell(pg_output_pin_two));

endmodule

// ===== src/pg_mask_defines.svh
// Constants for the power-good output mask bank: register indices, byte
// addresses, field positions, reset values and bus timing.
// Assumes inclusion by bare name from the package and the design module.
//
// Summary of operation
// [RQ1] Output high only when unmasked sources good.
// [RQ2] Pin four mask A: ldo2, switch A, bucks.
// [RQ3] Pin four mask B upper: enable inputs.
// [RQ4] Pin four mask B lower: other rails.
// [RQ5] Shared bit source chosen by OTP strap.
// [RQ6] Pin two mask A same rail layout.
// [RQ7] Masks software read/write; set bit ignores.
`ifndef PG_MASK_DEFINES_SVH
`define PG_MASK_DEFINES_SVH

// Printed offsets are register indices; byte address is four times these.
`define PGPIN4_MASK_A_IDX 8'hA6
`define PGPIN4_MASK_B_IDX 8'hA7
`define PGPIN2_MASK_A_IDX 8'hA8
`define REG_ADDR_W 12

// Reset value of every mask register (all sources included).
`define MASK_RESET 8'h00

// Field positions in the rail mask (A) registers.
`define MA_ADJ_LDO_TWO 7
`define MA_SWITCH_A_ONE 6
`define MA_STEP_DOWN_LO 0

// Field positions in the second mask (B) register.
`define MB_EN_FIVE 7
`define MB_EN_FOUR 6
`define MB_EN_TWO 5
`define MB_EN_ONE 4
`define MB_TERM 3
`define MB_SHARED 2
`define MB_SWITCH_B_ONE 1
`define MB_ADJ_LDO_THREE 0

// Edges after reset release before the strap synchroniser holds the pin.
`define STRAP_SETTLE 2'h2

// Access phase wait states inserted by the slave.
`define APB_WAIT_CYCLES 1

`endif

// ===== src/pg_mask_pkg.sv
// Types shared by the power-good output mask bank.
// Assumes the defines header is available on the include path.
`include "pg_mask_defines.svh"

package pg_mask_pkg;

    // One byte-wide mask register; a set bit removes its source.
    typedef logic [7:0] mask_type;

    // Register selected by the current bus address.
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_PIN4_A,
        SEL_PIN4_B,
        SEL_PIN2_A
    } reg_sel_type;

endpackage

// ===== verif/power_good_output_mask_bank_tb_top.sv
// Self-checking bench for the power-good output mask bank.
// Assumes the design sources and the defines header are on the include path.
`timescale 1ns/1ps
`include "pg_mask_defines.svh"

module power_good_output_mask_bank_tb_top;

////////////////////////////////////////////////////////////////////////////
// Byte addresses of the three masks, four times the register index.
localparam logic [11:0] A4A = 12'(4 * `PGPIN4_MASK_A_IDX);
localparam logic [11:0] A4B = 12'(4 * `PGPIN4_MASK_B_IDX);
localparam logic [11:0] A2A = 12'(4 * `PGPIN2_MASK_A_IDX);

// Bench-driven inputs, all given a value at time zero.
logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
logic pwrite = 1'b0, otp = 1'b0, sa1 = 1'b1, l2 = 1'b1, l3 = 1'b1;
logic sb1 = 1'b1, sb2 = 1'b1, l1 = 1'b1, tr = 1'b1, e1 = 1'b1, e2 = 1'b1;
logic e4 = 1'b1, e5 = 1'b1;
logic [5:0] sd = 6'h3F;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata;
logic pready, pslverr, pin4, pin2;
int failures = 0;
int num_checks = 0;

power_good_output_mask_bank uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_down_rail_pg(sd),
    .switch_a_one_pg(sa1), .adj_ldo_two_pg(l2), .adj_ldo_three_pg(l3),
    .switch_b_one_pg(sb1), .switch_b_two_pg(sb2), .adj_ldo_one_pg(l1),
    .termination_regulator_pg(tr), .enable_input_one(e1),
    .enable_input_two(e2), .enable_input_four(e4), .enable_input_five(e5),
    .otp_shared_is_ldo(otp), .pg_output_pin_four(pin4),
    .pg_output_pin_two(pin2)
);

// Free-running 100 MHz clock.
always #5 pclk = ~pclk;

////////////////////////////////////////////////////////////////////////////
// Ends the run; also reached when a bus wait runs out.
task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
        $display("STATUS OK");
    end else begin
        $display("STATUS NOT OK");
    end
    $finish;
endtask

// Compares a seen value with the expected one.
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
        failures++;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask

// One APB transfer; starts at an edge so two calls never collide.
task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
        @(posedge pclk);
        n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
        failures++;
        print_verdict();
    end
endtask

task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    chk(32'(er), 32'h0);
endtask

task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk(r, exp);
endtask

// Bit order follows mask A then mask B; the unselected shared source is 0.
task automatic drive(input logic [15:0] g);
    @(posedge pclk);
    sd <= g[5:0];
    sa1 <= g[6];
    l2 <= g[7];
    l3 <= g[8];
    sb1 <= g[9];
    l1 <= otp ? g[10] : 1'b0;
    sb2 <= otp ? 1'b0 : g[10];
    tr <= g[11];
    e1 <= g[12];
    e2 <= g[13];
    e4 <= g[14];
    e5 <= g[15];
endtask

// Outputs follow inputs three edges later, masks sooner.
task automatic expect_pins(input logic x4, input logic x2);
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(pin4), 32'(x4));
    chk(32'(pin2), 32'(x2));
endtask

task automatic reset_dut(input logic s);
    @(posedge pclk);
    presetn <= 1'b0;
    otp <= s;
    repeat (10) @(posedge pclk);
    chk(32'({pin4, pin2}), 32'h0);
    presetn <= 1'b1;
endtask

////////////////////////////////////////////////////////////////////////////
task automatic test_reset();
    rd_chk(A4A, 32'h0);
    rd_chk(A4B, 32'h0);
    rd_chk(A2A, 32'h0);
    drive(16'hFFFF);
    expect_pins(1'b1, 1'b1);
    $display("test_reset done");
endtask

// Every source low and every mask bit set: both pins must read good.
task automatic test_full_mask();
    drive(16'h0000);
    expect_pins(1'b0, 1'b0);
    wr(A4A, 32'hFF);
    wr(A4B, 32'hFF);
    wr(A2A, 32'hFF);
    expect_pins(1'b1, 1'b1);
    wr(A4A, 32'h0);
    wr(A4B, 32'h0);
    wr(A2A, 32'h0);
    $display("test_full_mask done");
endtask

// Read back with upper bits dropped, and an unmapped word refused.
task automatic test_rw();
    logic [31:0] r;
    logic er;
    wr(A4A, 32'hFFFF_FFA5);
    wr(A4B, 32'h1234_565A);
    wr(A2A, 32'h0000_00C3);
    rd_chk(A4A, 32'hA5);
    rd_chk(A4B, 32'h5A);
    rd_chk(A2A, 32'hC3);
    apb(1'b1, 12'h2A4, 32'hFF, r, er);
    chk(32'(er), 32'h1);
    apb(1'b0, 12'h2A4, 32'h0, r, er);
    chk({r[30:0], er}, 32'h1);
    wr(A4A, 32'h0);
    wr(A4B, 32'h0);
    wr(A2A, 32'h0);
    $display("test_rw done");
endtask

// Drop each source alone, then mask it in the pin four bank and, for mask A sources, in pin two's too.
task automatic test_walk();
    logic [11:0] ma;
    for (int i = 0; i < 16; i++) begin
        ma = (i < 8) ? A4A : A4B;
        drive(~(16'h0001 << i));
        expect_pins(1'b0, i >= 8);
        wr(ma, 32'h1 << (i % 8));
        expect_pins(1'b1, i >= 8);
        if (i < 8) begin
            wr(A2A, 32'h1 << i);
            expect_pins(1'b1, 1'b1);
            wr(A2A, 32'h0);
        end
        wr(ma, 32'h0);
    end
    $display("test_walk done");
endtask

// Strap flipped: the shared bit now follows the other source.
task automatic test_strap();
    reset_dut(1'b1);
    drive(16'hFFFF);
    expect_pins(1'b1, 1'b1);
    drive(16'hFBFF);
    expect_pins(1'b0, 1'b1);
    wr(A4B, 32'h4);
    expect_pins(1'b1, 1'b1);
    $display("test_strap done");
endtask

initial begin
    reset_dut(1'b0);
    test_reset();
    test_rw();
    test_full_mask();
    test_walk();
    test_strap();
    print_verdict();
end

endmodule
